// ===== verilog/dac_input_format_status.sv
// status register, input format register and input bus demultiplexer
`timescale 1ns/1ps
`default_nettype none
module dac_input_format_status #(
    parameter logic [2:0] PART_ID = 3'b101, // arbitrary value
    parameter logic [1:0] REVISION = 2'b01, // arbitrary value
    parameter int DEPTH = dac_fmt_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic pll_locked,
    input wire logic [dac_fmt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [dac_fmt_pkg::SAMPLE_W-1:0] bus_a,
    input wire logic [dac_fmt_pkg::SAMPLE_W-1:0] bus_b,
    input wire logic src_valid,
    output logic src_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [dac_fmt_pkg::SAMPLE_W-1:0] out_a,
    output logic [dac_fmt_pkg::SAMPLE_W-1:0] out_b,
    output logic single_stream,
    output logic [1:0] interp_sel,
    output logic clkin_sync_en
);
    import dac_fmt_pkg::*;

    logic lock_s1_q, lock_s2_q;
    logic [7:0] cfg_q, cfg_d, rdata_q, rdata_d;
    logic [SAMPLE_W-1:0] neg_a_q, neg_b_q, cap_a, cap_b;
    logic [SAMPLE_W-1:0] held_q, held_d;
    logic have_q, have_d, id_prev_q, id_prev_d;
    logic take, push, id_bit, rising;
    logic [2*SAMPLE_W-1:0] push_data;
    logic [2*SAMPLE_W-1:0] fifo_out;
    logic [SAMPLE_W-1:0] ilv_data;
    insel_type mode;
    logic twos, inv;

    // converts a raw sample to two's complement, flipping msb if needed
    function automatic logic [SAMPLE_W-1:0] to_twos(
        input logic [SAMPLE_W-1:0] s, input logic is_twos);
        to_twos = {s[SAMPLE_W-1] ^ ~is_twos, s[SAMPLE_W-2:0]};
    endfunction

    // ------------------------------------------------------------------
    // lock synchroniser and register file
    // ------------------------------------------------------------------
    assign mode = insel_type'(cfg_q[MODE_LSB +: 2]);
    assign twos = cfg_q[TWOS_BIT];
    assign inv = cfg_q[INV_BIT];
    assign reg_rdata = rdata_q;
    assign interp_sel = cfg_q[INTERP_LSB +: 2]; // R11
    assign clkin_sync_en = cfg_q[SYNC_BIT]; // R12
    assign single_stream = (mode == MODE_HALF); // R6

    // status writes fall through to nothing, only config is writable
    always_comb begin
        cfg_d = cfg_q;
        if (reg_wr && reg_addr == CFG_OFFSET) begin
            cfg_d = reg_wdata & CFG_WR_MASK; // R13
        end
        rdata_d = 8'h00;
        unique case (reg_addr)
            STATUS_OFFSET: begin
                rdata_d[LOCK_BIT] = lock_s2_q; // R1 R13
                rdata_d[PART_ID_LSB +: 3] = PART_ID; // R2
                rdata_d[REVISION_LSB +: 2] = REVISION; // R2
            end
            CFG_OFFSET: rdata_d = cfg_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
            cfg_q <= CFG_RESET;
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            lock_s1_q <= pll_locked;
            lock_s2_q <= lock_s1_q;
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // capture edge select
    // ------------------------------------------------------------------
    // the opposite edge copy is half a cycle older, giving setup margin
    always_ff @(negedge core_clk) begin
        if (!rst_n) begin
            neg_a_q <= '0;
            neg_b_q <= '0;
        end else if (clk_en) begin
            neg_a_q <= bus_a;
            neg_b_q <= bus_b;
        end
    end
    assign cap_a = inv ? neg_a_q : bus_a; // R10
    assign cap_b = inv ? neg_b_q : bus_b; // R10

    // ------------------------------------------------------------------
    // demultiplexer
    // ------------------------------------------------------------------
    // the fifo ready stalls the source and the pairing state alike
    assign take = src_valid && src_ready;
    assign id_bit = (mode == MODE_ILV_A) ? cap_b[SAMPLE_W-1]
                                         : cap_a[SAMPLE_W-1]; // R8
    assign rising = id_bit && !id_prev_q; // R7
    assign ilv_data = (mode == MODE_ILV_A) ? cap_a : cap_b;

    always_comb begin
        push = 1'b0;
        push_data = {to_twos(cap_a, twos), to_twos(cap_b, twos)}; // R9
        held_d = held_q;
        have_d = have_q;
        id_prev_d = id_prev_q;
        if (take) begin
            unique case (mode)
                MODE_DUAL, MODE_HALF: begin
                    push = 1'b1; // R3 R6
                    have_d = 1'b0;
                end
                MODE_ILV_A, MODE_ILV_B: begin
                    id_prev_d = id_bit;
                    if (rising) begin
                        held_d = ilv_data; // R7
                        have_d = 1'b1;
                    end else if (have_q) begin
                        push = 1'b1; // R4 R5
                        push_data = {to_twos(held_q, twos),
                                     to_twos(ilv_data, twos)};
                        have_d = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            held_q <= '0;
            have_q <= 1'b0;
            id_prev_q <= 1'b0;
        end else if (clk_en) begin
            held_q <= held_d;
            have_q <= have_d;
            id_prev_q <= id_prev_d;
        end
    end

    sample_fifo #(
        .WIDTH(2*SAMPLE_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(src_valid && (push || !take)),
        .in_ready(src_ready),
        .in_data(push_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_out)
    );
    // the fifo word carries channel a in its upper half
    assign out_a = fifo_out[2*SAMPLE_W-1 -: SAMPLE_W];
    assign out_b = fifo_out[SAMPLE_W-1:0];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    lock_sync_delay_a: assert property ( // R1
        $past(clk_en, 1) && $past(clk_en, 2) && $past(rst_n, 1)
        && $past(rst_n, 2)
        |-> lock_s2_q == $past(pll_locked, 2))
        else $error("lock bit does not follow loop after two cycles");
    status_read_value_a: assert property ( // R2
        clk_en && reg_addr == STATUS_OFFSET && !reg_wr
        |=> rdata_q == {$past(lock_s2_q), 2'b00, PART_ID, REVISION})
        else $error("status read value wrong");
    status_write_ignored_a: assert property ( // R13
        clk_en && reg_wr && reg_addr == STATUS_OFFSET |=> $stable(cfg_q))
        else $error("status write changed configuration");
    dual_mode_push_a: assert property ( // R3
        take && mode == MODE_DUAL |-> push
        && push_data[SAMPLE_W-1:0] == to_twos(cap_b, twos))
        else $error("dual mode did not forward bus b");
    ilv_rise_hold_a: assert property ( // R7
        clk_en && take && (mode == MODE_ILV_A || mode == MODE_ILV_B)
        && rising |-> !push ##1 have_q && held_q == $past(ilv_data))
        else $error("channel a sample not held on id rise");
    ilv_pair_push_a: assert property ( // R4
        take && mode == MODE_ILV_A && !rising && have_q
        |-> push && push_data == {to_twos(held_q, twos),
                                  to_twos(cap_a, twos)})
        else $error("interleaved pair not pushed");
    ilv_pair_b_a: assert property ( // R5
        take && mode == MODE_ILV_B && !rising && have_q
        |-> push && push_data == {to_twos(held_q, twos),
                                  to_twos(cap_b, twos)})
        else $error("bus b interleaved pair not pushed");
    offset_binary_a: assert property ( // R9
        take && mode == MODE_DUAL && !twos
        |-> push_data[2*SAMPLE_W-1] == ~cap_a[SAMPLE_W-1])
        else $error("offset binary msb not flipped");
    // the falling edge copy must hold what the buses showed at that edge
    inv_edge_a: assert property (@(negedge core_clk) // R10
        clk_en |=> neg_a_q == $past(bus_a) && neg_b_q == $past(bus_b))
        else $error("falling edge capture lost bus value");
endmodule // dac_input_format_status
`default_nettype wire

// ===== verilog/dac_fmt_pkg.sv
// constants shared by the input format and status register block
// Contract
// (R1) status top bit mirrors clock loop lock
// (R2) status holds fixed part id and revision
// (R3) select 00: bus A to A, bus B to B
// (R4) select 01: bus A interleaved, split to both
// (R5) select 10: bus B interleaved, split to both
// (R6) select 11: half rate buses form one stream
// (R7) idle bus id rising edge marks channel A
// (R8) source drives id high for A, low B
// (R9) format bit set two's complement, clear offset binary
// (R10) clock invert bit captures on opposite edge
// (R11) interpolation field selects 1X 2X 4X 8X
// (R12) sync bit enables input clock synchronisation
// (R13) status writes ignored, lock read live
`default_nettype none
package dac_fmt_pkg;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] STATUS_OFFSET = 5'h00;
    localparam logic [4:0] CFG_OFFSET = 5'h01;
    localparam logic [7:0] CFG_RESET = 8'h0B;
    localparam logic [7:0] CFG_WR_MASK = 8'hDF; // bit 5 unused
    localparam int LOCK_BIT = 7;
    localparam int PART_ID_LSB = 2;
    localparam int REVISION_LSB = 0;
    localparam int MODE_LSB = 6;
    localparam int SYNC_BIT = 4;
    localparam int TWOS_BIT = 3;
    localparam int INV_BIT = 2;
    localparam int INTERP_LSB = 0;
    // ------------------------------------------------------------------
    // data path
    // ------------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int FIFO_DEPTH = 32;
    typedef enum logic [1:0] {
        MODE_DUAL = 2'b00,
        MODE_ILV_A = 2'b01,
        MODE_ILV_B = 2'b10,
        MODE_HALF = 2'b11
    } insel_type;
    typedef enum logic [1:0] {
        INTERP_1X = 2'b00,
        INTERP_2X = 2'b01,
        INTERP_4X = 2'b10,
        INTERP_8X = 2'b11
    } interp_type;
endpackage
`default_nettype wire

// ===== verilog/sample_fifo.sv
// sample fifo with registered read data and valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [PW:0] count_q, count_d;
    logic out_valid_q, out_valid_d;
    logic [WIDTH-1:0] out_data_q, out_data_d;
    logic push, pop;

    // ------------------------------------------------------------------
    // pointers and output stage
    // ------------------------------------------------------------------
    // full is counted in the array only, the output register is extra
    assign in_ready = (count_q != DEPTH_C) && clk_en;
    assign push = in_valid && in_ready;
    assign pop = (count_q != '0) && (!out_valid_q || out_ready) && clk_en;
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;

    always_comb begin
        wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);
        out_valid_d = out_valid_q;
        out_data_d = out_data_q;
        if (pop) begin
            out_valid_d = 1'b1;
            out_data_d = mem_q[rd_ptr_q];
        end else if (out_ready) begin
            out_valid_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (clk_en) begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            out_valid_q <= out_valid_d;
            out_data_q <= out_data_d;
        end
    end

    // storage has no reset, only written words are ever read
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end
endmodule // sample_fifo
`default_nettype wire

// ===== tb/sample_source.sv
// sample source model driving both input buses under valid/ready
`timescale 1ns/1ps
`default_nettype none
module sample_source (
    input wire logic core_clk,
    input wire logic src_ready,
    output logic [dac_fmt_pkg::SAMPLE_W-1:0] bus_a,
    output logic [dac_fmt_pkg::SAMPLE_W-1:0] bus_b,
    output logic src_valid
);
    import dac_fmt_pkg::*;
    initial begin
        src_valid = 1'b0;
        bus_a = '0;
        bus_b = '0;
    end
    // offer one pair for one edge, report whether it was taken
    task automatic offer(input logic [15:0] a, input logic [15:0] b,
                         output logic took);
        src_valid = 1'b1;
        bus_a = a;
        bus_b = b;
        @(negedge core_clk);
        took = src_ready;
        @(posedge core_clk);
        #1;
    endtask
    // hold the pair until an edge sees ready high
    task automatic send(input logic [15:0] a, input logic [15:0] b);
        logic took;
        do offer(a, b, took); while (!took);
    endtask
    // interleaved sample: data on one bus, channel id on the other msb
    task automatic send_ch(input logic on_b, input logic is_a,
                           input logic [15:0] d);
        logic [15:0] id;
        id = {is_a, 15'h0000};
        if (on_b) begin
            send(id, d);
        end else begin
            send(d, id);
        end
    endtask
    // data timed to the falling edge: it moves again before the rising one
    task automatic send_skew(input logic [15:0] a, input logic [15:0] b);
        src_valid = 1'b1;
        bus_a = a;
        bus_b = b;
        @(negedge core_clk);
        #1;
        bus_a = ~a;
        bus_b = ~b;
        @(posedge core_clk);
        #1;
    endtask
    // released buses show the inverse so stale data never passes
    task automatic idle();
        src_valid = 1'b0;
        bus_a = ~bus_a;
        bus_b = ~bus_b;
    endtask
endmodule // sample_source
`default_nettype wire

// ===== tb/tb_dac_input_format_status.sv
// self-checking bench for the input format and status register block
`timescale 1ns/1ps
`default_nettype none
module tb_dac_input_format_status;
    import dac_fmt_pkg::*;
    localparam logic [2:0] PID = 3'b110; // arbitrary value
    localparam logic [1:0] REV = 2'b10; // arbitrary value
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic pll_locked = 1'b0;
    logic out_ready = 1'b1;
    logic reg_wr = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic [7:0] reg_rdata;
    logic [SAMPLE_W-1:0] bus_a, bus_b, out_a, out_b;
    logic src_valid, src_ready, out_valid, single_stream, clkin_sync_en;
    logic took;
    logic [1:0] interp_sel;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    logic [31:0] exp_q[$];
    logic [31:0] got_q[$];
    always #10 core_clk = ~core_clk;
    dac_input_format_status #(.PART_ID(PID), .REVISION(REV)) u_dut (
        .core_clk, .rst_n, .clk_en, .pll_locked, .reg_addr, .reg_wr,
        .reg_wdata, .reg_rdata, .bus_a, .bus_b, .src_valid, .src_ready,
        .out_valid, .out_ready, .out_a, .out_b, .single_stream,
        .interp_sel, .clkin_sync_en);
    sample_source u_src (.core_clk, .src_ready, .bus_a, .bus_b, .src_valid);
    // collect each pair handed downstream; handshake lands next edge
    always @(negedge core_clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got_q.push_back({out_a, out_b});
        end
    end
    // hang guard, far above the fewer than two hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            summarize();
        end
    end
    task automatic chk_reg(input string w, input logic [7:0] e,
                           input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk_pair(input string w, input logic [31:0] e,
                            input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
    endtask
    // read data is registered: one edge after the address
    task automatic reg_read(input logic [4:0] a, input logic [7:0] e);
        reg_addr = a;
        step();
        chk_reg("reg_rdata", e, reg_rdata);
    endtask
    // wait for all expected pairs, then compare them in order
    task automatic drain(input string name);
        int k = 0;
        while (got_q.size() < exp_q.size() && k < 200) begin
            step();
            k++;
        end
        repeat (4) step();
        chk_reg("pair count", 8'(exp_q.size()), 8'(got_q.size()));
        foreach (exp_q[i]) begin
            if (i < got_q.size()) chk_pair("pair", exp_q[i], got_q[i]);
        end
        exp_q.delete();
        got_q.delete();
        $display("end of test %s", name);
    endtask
    function automatic logic [15:0] fmt(logic [15:0] s, logic tw);
        return tw ? s : s ^ 16'h8000;
    endfunction
    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        reg_read(STATUS_OFFSET, {3'b000, PID, REV});
        reg_read(CFG_OFFSET, CFG_RESET);
        chk_reg("interp_sel", 8'h03, {6'h00, interp_sel});
        chk_reg("sync", 8'h00, {7'h00, clkin_sync_en});
        reg_read(5'h1F, 8'h00);
        reg_write(STATUS_OFFSET, 8'hFF);
        reg_read(CFG_OFFSET, CFG_RESET);
        pll_locked = 1'b1;
        repeat (3) step();
        reg_read(STATUS_OFFSET, {3'b100, PID, REV});
        pll_locked = 1'b0;
        repeat (3) step();
        reg_read(STATUS_OFFSET, {3'b000, PID, REV});
        $display("end of test registers");
        for (int i = 0; i < 4; i++) begin
            reg_write(CFG_OFFSET, 8'h18 | 8'(i));
            reg_read(CFG_OFFSET, 8'h18 | 8'(i));
            chk_reg("interp_sel", 8'(i), {6'h00, interp_sel});
            chk_reg("sync", 8'h01, {7'h00, clkin_sync_en});
        end
        reg_write(CFG_OFFSET, 8'hFF);
        reg_read(CFG_OFFSET, 8'hDF);
        chk_reg("single", 8'h01, {7'h00, single_stream});
        for (int tw = 0; tw < 2; tw++) begin
            reg_write(CFG_OFFSET, {4'h0, tw[0], 3'b011});
            u_src.send(16'h1234, 16'h8765);
            u_src.send(16'h0F00, 16'hFFFF);
            u_src.idle();
            exp_q.push_back({fmt(16'h1234, tw[0]), fmt(16'h8765, tw[0])});
            exp_q.push_back({fmt(16'h0F00, tw[0]), fmt(16'hFFFF, tw[0])});
            drain("dual");
        end
        reg_write(CFG_OFFSET, 8'h0F);
        u_src.send(16'h0F0F, 16'hF0F0);
        u_src.send_skew(16'h1357, 16'h2468);
        u_src.idle();
        exp_q.push_back(32'h0F0F_F0F0);
        exp_q.push_back(32'h1357_2468);
        drain("inverted capture");
        for (int m = 1; m < 3; m++) begin
            reg_write(CFG_OFFSET, {m[1:0], 6'h0B});
            chk_reg("single", 8'h00, {7'h00, single_stream});
            u_src.send_ch(m == 2, 1'b0, 16'h0BAD);
            u_src.send_ch(m == 2, 1'b1, 16'h1234);
            u_src.send_ch(m == 2, 1'b0, 16'h5678);
            u_src.send_ch(m == 2, 1'b1, 16'h9ABC);
            u_src.send_ch(m == 2, 1'b0, 16'hDEF0);
            u_src.idle();
            exp_q.push_back(32'h1234_5678);
            exp_q.push_back(32'h9ABC_DEF0);
            drain("interleaved");
        end
        reg_write(CFG_OFFSET, 8'hCB);
        chk_reg("single", 8'h01, {7'h00, single_stream});
        u_src.send(16'h0102, 16'h0304);
        u_src.idle();
        exp_q.push_back(32'h0102_0304);
        drain("half rate");
        reg_write(CFG_OFFSET, 8'h0B);
        clk_en = 1'b0;
        step();
        chk_reg("ready frozen", 8'h00, {7'h00, src_ready});
        clk_en = 1'b1;
        out_ready = 1'b0;
        n = 0;
        took = 1'b1;
        while (took && n < 40) begin
            u_src.offer(16'(n), ~16'(n), took);
            if (took) begin
                exp_q.push_back({16'(n), ~16'(n)});
                n++;
            end
        end
        u_src.idle();
        chk_reg("fill", 8'(FIFO_DEPTH + 1), 8'(n));
        out_ready = 1'b1;
        drain("fill and drain");
        summarize();
    end
endmodule // tb_dac_input_format_status
`default_nettype wire
